// ==== common/lsc_pkg.sv ====
// Shared constants, register map and types for the LED supply and sink control block.
package lsc_pkg;

   // Counts of sinks, banks and pattern sources.
   localparam int NUM_HV = 2;
   localparam int NUM_LV = 5;
   localparam int NUM_BANKS = 6;
   localparam int FIRST_LV_BANK = 2;
   localparam int NUM_PATTERN = 4;

   // Clock rate and the capacitor-detection timeout; a longest time rounds down.
   localparam int CLOCK_MHZ = 20;
   localparam int DETECT_TIMEOUT_NS = 20000;
   localparam int DETECT_TIMEOUT_CYCLES = (DETECT_TIMEOUT_NS * CLOCK_MHZ) / 1000;

   // Register offsets on the serial register interface.
   localparam logic [7:0] REG_ANODE = 8'h00;
   localparam logic [7:0] REG_BOOST = 8'h01;
   localparam logic [7:0] REG_PUMP = 8'h02;
   localparam logic [7:0] REG_BANK_EN = 8'h03;
   localparam logic [7:0] REG_LV_MAP_LO = 8'h04;
   localparam logic [7:0] REG_LV_MAP_HI = 8'h05;
   localparam logic [7:0] REG_PUMP_STAT = 8'h06;
   localparam logic [7:0] REG_HV_MAP = 8'h07;
   localparam logic [7:0] REG_BANK_CFG = 8'h10;
   localparam logic [7:0] REG_FULL_SCALE = 8'h18;
   localparam logic [7:0] REG_BRIGHT = 8'h20;

   // Reset values.
   localparam logic [6:0] ANODE_RESET = 7'h7F;
   localparam logic [1:0] BOOST_RESET = 2'h0;
   localparam logic [5:0] BANK_EN_RESET = 6'h00;
   localparam logic [9:0] LV_MAP_RESET = 10'h000;
   localparam logic [1:0] HV_MAP_RESET = 2'h0;
   localparam logic [3:0] BANK_CFG_RESET = 4'h0;
   localparam logic [4:0] FULL_SCALE_RESET = 5'h00;
   localparam logic [7:0] BRIGHT_RESET = 8'h00;

   // Field positions.
   localparam int ANODE_HV_LSB = 0;
   localparam int ANODE_LV_LSB = 2;
   localparam int BOOST_PWM_POL_BIT = 0;
   localparam int BOOST_FREQ_BIT = 1;
   localparam int CFG_LINEAR_BIT = 0;
   localparam int CFG_PWM_BIT = 1;
   localparam int CFG_ALS_BIT = 2;
   localparam int CFG_PATTERN_BIT = 3;

   // Exponential mapping in log2 fixed point with eight fraction bits.
   localparam logic [11:0] EXP_STEP = 12'h00A;
   localparam logic [11:0] EXP_OFFSET = 12'h003;

   typedef enum logic [1:0] {
      PUMP_OFF = 2'b00,
      PUMP_AUTO = 2'b01,
      PUMP_FORCE_1X = 2'b10,
      PUMP_FORCE_2X = 2'b11
   } lsc_pump_mode_t;

   typedef enum logic [2:0] {
      PS_OFF = 3'b000,
      PS_DETECT = 3'b001,
      PS_AUTO_1X = 3'b010,
      PS_AUTO_2X = 3'b011,
      PS_FORCE_1X = 3'b100,
      PS_FORCE_2X = 3'b101,
      PS_FALLBACK = 3'b110
   } lsc_pump_state_t;

   typedef enum logic [2:0] {
      BS_IDLE = 3'b000,
      BS_ADDR = 3'b001,
      BS_REG = 3'b010,
      BS_WRITE = 3'b011,
      BS_READ = 3'b100
   } lsc_bus_state_t;

endpackage : lsc_pkg

// ==== src/lsc_current_map.sv ====
// Brightness-code to sink-current mapper for one control bank.
`timescale 1ns/10ps
module lsc_current_map
   import lsc_pkg::*;
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic enable,
   input wire logic linearMode,
   input wire logic pwmApply,
   input wire logic [7:0] pwmDuty,
   input wire logic [4:0] fullScale,
   input wire logic [7:0] code,
   output logic [15:0] level
);

   // Exponential law: each code step below full code lowers the current by a fixed log2 step.
   wire logic [7:0] codeDist = 8'hFF - code;
   wire logic [11:0] expLog = 12'(codeDist * EXP_STEP) + EXP_OFFSET;
   // A straight line between octaves keeps this free of a table; error stays under seven percent.
   wire logic [8:0] mant = 9'h100 - {2'h0, expLog[7:1]};
   wire logic [16:0] expFrac = {mant, 8'h00} >> expLog[11:8];
   // Linear law: code times 257 puts code 255 at full scale.
   wire logic [16:0] linFrac = {1'b0, 16'(code * 16'h0101)};
   wire logic [16:0] frac = linearMode ? linFrac : expFrac;

   // Full scale, then the duty cycle of the PWM input when the bank uses it.
   wire logic [5:0] fsSteps = {1'b0, fullScale} + 6'h01;
   wire logic [22:0] scaled = 23'(frac * fsSteps);
   wire logic [8:0] dutyScale = pwmApply ? ({1'b0, pwmDuty} + {8'h00, pwmDuty[7]}) : 9'h100;
   wire logic [26:0] prod = 27'(scaled[22:5] * dutyScale);
   wire logic [18:0] shifted = prod[26:8];
   wire logic [15:0] levelNxt = !enable ? 16'h0000 : ((|shifted[18:16]) ? 16'hFFFF : shifted[15:0]);

   // The level is registered so the analog sink sees a glitch-free word.
   always_ff @(posedge clock) begin
      if (!nrst) begin
         level <= 16'h0000;
      end else begin
         level <= levelNxt;
      end
   end

endmodule : lsc_current_map

// ==== src/lsc_sink_control.sv ====
// Register file, serial slave, charge-pump mode control and bank mapping for the LED supply and sinks.
//
// What this block does
// - Two anode-routing bits choose boost output or external supply per high-voltage sink.
// - High-voltage routing bit 1, default, joins the boost feedback; 0 excludes it.
// - One bit selects boost switching at 500 kHz or 1 MHz.
// - The charge pump has four modes: off, automatic, forced 1x, forced 2x.
// - Pump off makes its output high impedance; low-voltage sinks are untouched.
// - With the pump off, pump-fed low-voltage sinks keep sinking their current.
// - Automatic mode starts in pass-through 1x gain.
// - Automatic mode goes to 2x when an active pump-fed sink nears dropout.
// - Once in 2x, automatic mode stays there though headroom returns.
// - Automatic mode checks the flying capacitor first; if missing it stays at 1x.
// - Forced 1x never switches and passes the supply straight through.
// - Five routing bits mark pump-fed low-voltage sinks; 1, default, joins the decision.
// - Each routing bit also sets how that sink's short fault is judged.
// - Each high-voltage sink has a 5-bit full scale and 8-bit code.
// - A high-voltage bank takes its code from its brightness register or ambient light.
// - Low-voltage sinks take code from register, PWM, ambient light or a mix.
// - Low-voltage sinks may carry codes from four pattern generators.
// - Any low-voltage sink maps to any of four low-voltage banks.
// - Every bank chooses exponential or linear code-to-current mapping.
// - Exponential: full scale times 0.862^(46.6-(code+1)/5.5) times duty.
// - Linear: full scale times code/255 times duty.
// - Hardware enable low shuts down and returns every register to default.
`timescale 1ns/10ps
module lsc_sink_control
   import lsc_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = 7'h36, // Arbitrary slave address.
   parameter int DETECT_CYCLES = DETECT_TIMEOUT_CYCLES
)(
   input wire logic clock,
   input wire logic nrst,
   input wire logic hardwareEnablePin,
   input wire logic sclPin,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOe,
   input wire logic [7:0] pwmDuty,
   input wire logic [7:0] alsCode,
   input wire logic [NUM_PATTERN-1:0][7:0] patternCode,
   input wire logic [NUM_LV-1:0] lvDropout,
   input wire logic capDetectDone,
   input wire logic capPresent,
   output logic shutdown,
   output logic boostFreq1MHz,
   output logic [NUM_HV-1:0] boostFeedbackSel,
   output logic [NUM_LV-1:0] pumpFeedbackSel,
   output logic [NUM_HV+NUM_LV-1:0] shortFaultRef,
   output logic pumpEnable,
   output logic pumpSwitching,
   output logic pumpGain2x,
   output logic capDetectReq,
   output logic [NUM_HV-1:0][15:0] hvSinkLevel,
   output logic [NUM_LV-1:0][15:0] lvSinkLevel
);

   localparam int SYNC_W = 10;

   // Pins from outside the clock domain pass two flip-flops; only the second stage is read.
   logic [SYNC_W-1:0] sync1_r;
   logic [SYNC_W-1:0] sync2_r;
   always_ff @(posedge clock) begin
      if (!nrst) begin
         sync1_r <= '0;
         sync2_r <= '0;
      end else begin
         sync1_r <= {hardwareEnablePin, sclPin, sdaIn, lvDropout, capDetectDone, capPresent};
         sync2_r <= sync1_r;
      end
   end

   wire logic hwenS = sync2_r[9];
   wire logic sclS = sync2_r[8];
   wire logic sdaS = sync2_r[7];
   wire logic [NUM_LV-1:0] dropS = sync2_r[6:2];
   wire logic capDoneS = sync2_r[1];
   wire logic capPresentS = sync2_r[0];

   // Hardware enable low holds every register at its default, like a reset.
   wire logic softRst = !nrst || !hwenS;

   // ---------------- Serial register slave ----------------
   logic sclD_r;
   logic sdaD_r;
   lsc_bus_state_t busState_r;
   logic [7:0] shift_r;
   logic [3:0] bitCnt_r;
   logic ackPhase_r;
   logic readMode_r;
   logic [7:0] ptr_r;
   logic sdaOe_r;
   logic [7:0] readData;

   // Start and stop are seen while the clock line is high.
   wire logic sclRise = sclS && !sclD_r;
   wire logic sclFall = !sclS && sclD_r;
   wire logic startCond = sclS && sclD_r && sdaD_r && !sdaS;
   wire logic stopCond = sclS && sclD_r && !sdaD_r && sdaS;
   wire logic byteDone = sclFall && !ackPhase_r && (bitCnt_r == 4'h8);
   wire logic addrHit = shift_r[7:1] == DEV_ADDR;
   wire logic wrStb = byteDone && (busState_r == BS_WRITE);
   wire logic [7:0] wrAddr = ptr_r;
   wire logic [7:0] wrData = shift_r;
   wire logic rdLoad = sclFall && ackPhase_r && ((busState_r == BS_ADDR && readMode_r) || busState_r == BS_READ);

   always_ff @(posedge clock) begin
      if (softRst) begin
         sclD_r <= 1'b1;
         sdaD_r <= 1'b1;
      end else begin
         sclD_r <= sclS;
         sdaD_r <= sdaS;
      end
   end

   // Byte sequencing: address, register pointer, then write bytes or read bytes with auto-increment.
   always_ff @(posedge clock) begin
      if (softRst || stopCond) begin
         busState_r <= BS_IDLE;
         ackPhase_r <= 1'b0;
         bitCnt_r <= 4'h0;
         sdaOe_r <= 1'b0;
         readMode_r <= 1'b0;
         shift_r <= 8'h00;
      end else if (startCond) begin
         busState_r <= BS_ADDR;
         ackPhase_r <= 1'b0;
         bitCnt_r <= 4'h0;
         sdaOe_r <= 1'b0;
      end else if (sclRise && !ackPhase_r && busState_r != BS_IDLE && busState_r != BS_READ) begin
         shift_r <= {shift_r[6:0], sdaS};
         bitCnt_r <= bitCnt_r + 4'h1;
      end else if (sclRise && busState_r == BS_READ) begin
         if (ackPhase_r && sdaS) begin
            busState_r <= BS_IDLE; // The master's not-acknowledge ends the read.
         end else if (!ackPhase_r) begin
            bitCnt_r <= bitCnt_r + 4'h1;
         end
      end else if (byteDone) begin
         ackPhase_r <= 1'b1;
         bitCnt_r <= 4'h0;
         if (busState_r == BS_ADDR && !addrHit) begin
            busState_r <= BS_IDLE;
         end else if (busState_r == BS_READ) begin
            sdaOe_r <= 1'b0;
         end else begin
            sdaOe_r <= 1'b1;
            if (busState_r == BS_ADDR) begin
               readMode_r <= shift_r[0];
            end
         end
      end else if (rdLoad) begin
         ackPhase_r <= 1'b0;
         busState_r <= BS_READ;
         sdaOe_r <= !readData[7];
         shift_r <= {readData[6:0], 1'b0};
      end else if (sclFall && ackPhase_r) begin
         ackPhase_r <= 1'b0;
         sdaOe_r <= 1'b0;
         busState_r <= (busState_r == BS_ADDR) ? BS_REG : ((busState_r == BS_IDLE) ? BS_IDLE : BS_WRITE);
      end else if (sclFall && busState_r == BS_READ && !ackPhase_r && bitCnt_r != 4'h8) begin
         sdaOe_r <= !shift_r[7];
         shift_r <= {shift_r[6:0], 1'b0};
      end
   end

   // The pointer follows the register byte and steps after every byte written or loaded for reading.
   always_ff @(posedge clock) begin
      if (softRst) begin
         ptr_r <= 8'h00;
      end else if (byteDone && busState_r == BS_REG) begin
         ptr_r <= shift_r;
      end else if (wrStb || rdLoad) begin
         ptr_r <= ptr_r + 8'h01;
      end
   end

   assign sdaOut = 1'b0;
   assign sdaOe = sdaOe_r;

   // ---------------- Register file ----------------
   logic [6:0] anode_r;
   logic [1:0] boostCfg_r;
   lsc_pump_mode_t pumpMode_r;
   logic [5:0] bankEn_r;
   logic [9:0] lvMap_r;
   logic [1:0] hvMap_r;
   logic [NUM_BANKS-1:0][3:0] bankCfg_r;
   logic [NUM_BANKS-1:0][4:0] fullScale_r;
   logic [NUM_BANKS-1:0][7:0] bright_r;
   logic [3:0] pumpStat;

   wire logic wrAnode = wrStb && wrAddr == REG_ANODE;
   wire logic wrBoost = wrStb && wrAddr == REG_BOOST;
   wire logic wrPump = wrStb && wrAddr == REG_PUMP;
   wire logic wrBankEn = wrStb && wrAddr == REG_BANK_EN;
   wire logic wrMapLo = wrStb && wrAddr == REG_LV_MAP_LO;
   wire logic wrMapHi = wrStb && wrAddr == REG_LV_MAP_HI;
   wire logic wrHvMap = wrStb && wrAddr == REG_HV_MAP;

   // Single registers; reserved bits are dropped on write.
   always_ff @(posedge clock) begin
      if (softRst) begin
         anode_r <= ANODE_RESET;
         boostCfg_r <= BOOST_RESET;
         pumpMode_r <= PUMP_OFF;
         bankEn_r <= BANK_EN_RESET;
         lvMap_r <= LV_MAP_RESET;
         hvMap_r <= HV_MAP_RESET;
      end else begin
         if (wrAnode) anode_r <= wrData[6:0];
         if (wrBoost) boostCfg_r <= wrData[1:0];
         if (wrPump) pumpMode_r <= lsc_pump_mode_t'(wrData[1:0]);
         if (wrBankEn) bankEn_r <= wrData[5:0];
         if (wrMapLo) lvMap_r[7:0] <= wrData;
         if (wrMapHi) lvMap_r[9:8] <= wrData[1:0];
         if (wrHvMap) hvMap_r <= wrData[1:0];
      end
   end

   // Per-bank registers and one mapper per bank.
   genvar b;
   generate
      for (b = 0; b < NUM_BANKS; b++) begin : gBank
         wire logic wrCfg = wrStb && wrAddr == (REG_BANK_CFG + 8'(b));
         wire logic wrFs = wrStb && wrAddr == (REG_FULL_SCALE + 8'(b));
         wire logic wrBr = wrStb && wrAddr == (REG_BRIGHT + 8'(b));
         logic [7:0] patCode;
         logic [7:0] bankCode;
         logic [15:0] bankLevel;

         always_ff @(posedge clock) begin
            if (softRst) begin
               bankCfg_r[b] <= BANK_CFG_RESET;
               fullScale_r[b] <= FULL_SCALE_RESET;
               bright_r[b] <= BRIGHT_RESET;
            end else begin
               if (wrCfg) bankCfg_r[b] <= wrData[3:0];
               if (wrFs) fullScale_r[b] <= wrData[4:0];
               if (wrBr) bright_r[b] <= wrData;
            end
         end

         // Only the low-voltage banks can take a pattern generator's code.
         if (b >= FIRST_LV_BANK) begin : gPat
            assign patCode = patternCode[b-FIRST_LV_BANK];
         end else begin : gNoPat
            assign patCode = 8'h00;
         end

         wire logic usePat = bankCfg_r[b][CFG_PATTERN_BIT] && (b >= FIRST_LV_BANK);
         assign bankCode = bankCfg_r[b][CFG_ALS_BIT] ? alsCode : (usePat ? patCode : bright_r[b]);
         wire logic [7:0] dutyPol = boostCfg_r[BOOST_PWM_POL_BIT] ? (8'hFF - pwmDuty) : pwmDuty;

         lsc_current_map uMap (
            .clock(clock),
            .nrst(!softRst),
            .enable(bankEn_r[b]),
            .linearMode(bankCfg_r[b][CFG_LINEAR_BIT]),
            .pwmApply(bankCfg_r[b][CFG_PWM_BIT]),
            .pwmDuty(dutyPol),
            .fullScale(fullScale_r[b]),
            .code(bankCode),
            .level(bankLevel)
         );
      end
   endgenerate

   // Sinks copy the level of the bank they are mapped to; pump mode does not gate them.
   genvar s;
   generate
      for (s = 0; s < NUM_HV; s++) begin : gHv
         assign hvSinkLevel[s] = hvMap_r[s] ? gBank[1].bankLevel : gBank[0].bankLevel;
      end
      for (s = 0; s < NUM_LV; s++) begin : gLv
         wire logic [1:0] sel = lvMap_r[2*s +: 2];
         assign lvSinkLevel[s] = (sel == 2'h0) ? gBank[2].bankLevel : (sel == 2'h1) ? gBank[3].bankLevel
                               : (sel == 2'h2) ? gBank[4].bankLevel : gBank[5].bankLevel;
      end
   endgenerate

   // A low-voltage sink counts as active when the bank it is mapped to is enabled.
   logic [NUM_LV-1:0] lvActive;
   always_comb begin
      for (int i = 0; i < NUM_LV; i++) begin
         lvActive[i] = bankEn_r[FIRST_LV_BANK + 32'(lvMap_r[2*i +: 2])];
      end
   end

   // Read-back mux; unmapped offsets read as zero.
   always_comb begin
      readData = 8'h00;
      if (ptr_r >= REG_BANK_CFG && ptr_r < REG_BANK_CFG + 8'(NUM_BANKS)) begin
         readData = {4'h0, bankCfg_r[ptr_r[2:0]]};
      end else if (ptr_r >= REG_FULL_SCALE && ptr_r < REG_FULL_SCALE + 8'(NUM_BANKS)) begin
         readData = {3'h0, fullScale_r[ptr_r[2:0]]};
      end else if (ptr_r >= REG_BRIGHT && ptr_r < REG_BRIGHT + 8'(NUM_BANKS)) begin
         readData = bright_r[ptr_r[2:0]];
      end else begin
         case (ptr_r)
            REG_ANODE: readData = {1'b0, anode_r};
            REG_BOOST: readData = {6'h00, boostCfg_r};
            REG_PUMP: readData = {6'h00, pumpMode_r};
            REG_BANK_EN: readData = {2'h0, bankEn_r};
            REG_LV_MAP_LO: readData = lvMap_r[7:0];
            REG_LV_MAP_HI: readData = {6'h00, lvMap_r[9:8]};
            REG_PUMP_STAT: readData = {4'h0, pumpStat};
            REG_HV_MAP: readData = {6'h00, hvMap_r};
            default: readData = 8'h00;
         endcase
      end
   end

   // ---------------- Charge-pump mode control ----------------
   lsc_pump_state_t pump_r;
   lsc_pump_state_t pump_nxt;
   logic [15:0] detCnt_r;

   // Only active sinks routed to the pump output may request 2x.
   wire logic dropHit = |(dropS & anode_r[ANODE_LV_LSB +: NUM_LV] & lvActive);
   wire logic detTimeout = detCnt_r >= 16'(DETECT_CYCLES - 1);

   // Any mode other than automatic forces its own state, which also drops the 2x latch.
   always_comb begin
      pump_nxt = pump_r;
      case (pumpMode_r)
         PUMP_OFF: pump_nxt = PS_OFF;
         PUMP_FORCE_1X: pump_nxt = PS_FORCE_1X;
         PUMP_FORCE_2X: pump_nxt = PS_FORCE_2X;
         PUMP_AUTO: begin
            case (pump_r)
               PS_DETECT: begin
                  if (capDoneS) begin
                     pump_nxt = capPresentS ? PS_AUTO_1X : PS_FALLBACK;
                  end else if (detTimeout) begin
                     pump_nxt = PS_FALLBACK;
                  end
               end
               PS_AUTO_1X: pump_nxt = dropHit ? PS_AUTO_2X : PS_AUTO_1X;
               PS_AUTO_2X: pump_nxt = PS_AUTO_2X;
               PS_FALLBACK: pump_nxt = PS_FALLBACK;
               default: pump_nxt = PS_DETECT;
            endcase
         end
         default: pump_nxt = PS_OFF;
      endcase
   end

   // The detection timer bounds the wait in case the detector never answers.
   always_ff @(posedge clock) begin
      if (softRst) begin
         pump_r <= PS_OFF;
         detCnt_r <= 16'h0000;
      end else begin
         pump_r <= pump_nxt;
         detCnt_r <= (pump_r == PS_DETECT) ? detCnt_r + 16'h0001 : 16'h0000;
      end
   end

   // Pump controls are registered from the next state, so they change with the state.
   always_ff @(posedge clock) begin
      if (softRst) begin
         pumpEnable <= 1'b0;
         pumpSwitching <= 1'b0;
         pumpGain2x <= 1'b0;
         capDetectReq <= 1'b0;
      end else begin
         pumpEnable <= pump_nxt != PS_OFF;
         pumpSwitching <= pump_nxt == PS_AUTO_2X || pump_nxt == PS_FORCE_2X;
         pumpGain2x <= pump_nxt == PS_AUTO_2X || pump_nxt == PS_FORCE_2X;
         capDetectReq <= pump_nxt == PS_DETECT;
      end
   end

   assign pumpStat = {pumpEnable, pump_r == PS_FALLBACK, pumpSwitching, pumpGain2x};

   // Static outputs straight from the routing and boost registers; shutdown comes from the synchronised enable pin.
   assign shutdown = !hwenS;
   assign boostFreq1MHz = boostCfg_r[BOOST_FREQ_BIT];
   assign boostFeedbackSel = anode_r[ANODE_HV_LSB +: NUM_HV];
   assign pumpFeedbackSel = anode_r[ANODE_LV_LSB +: NUM_LV];
   assign shortFaultRef = anode_r;

endmodule : lsc_sink_control

// ==== tb/led_supply_sink_control_bench.sv ====
// Self-checking bench for the sink control block.
`timescale 1ns/10ps
module led_supply_sink_control_bench;
   import lsc_pkg::*;
   logic clock, nrst, hardware_enable_pin, sclPin, sdaDrv, sdaOut, sdaOe, shutdown, boostFreq1MHz;
   logic pumpEnable, pumpSwitching, pumpGain2x, capDetectReq, capDetectDone, capPresent;
   logic [NUM_LV-1:0] lvDropout, pumpFeedbackSel;
   logic [NUM_HV-1:0] boostFeedbackSel;
   logic [NUM_HV+NUM_LV-1:0] shortFaultRef;
   logic [NUM_HV-1:0][15:0] hvSinkLevel;
   logic [NUM_LV-1:0][15:0] lvSinkLevel;
   logic [NUM_PATTERN-1:0][7:0] patternCode;
   logic [7:0] pwmDuty, alsCode;
   logic [1:0] modes [3] = '{PUMP_FORCE_1X, PUMP_FORCE_2X, PUMP_OFF};
   logic [2:0] expv [3] = '{3'b100, 3'b111, 3'b000};
   int err_count, checks;
   // Pulled-up data line, pulled low by either party.
   wire sdaLine = sdaDrv & ~(sdaOe & ~sdaOut);
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   lsc_sink_control #(.DETECT_CYCLES(8)) DUT (.clock, .nrst, .hardwareEnablePin(hardware_enable_pin), .sclPin, .sdaIn(sdaLine),
      .sdaOut, .sdaOe, .pwmDuty, .alsCode, .patternCode, .lvDropout, .capDetectDone, .capPresent, .shutdown,
      .boostFreq1MHz, .boostFeedbackSel, .pumpFeedbackSel, .shortFaultRef, .pumpEnable, .pumpSwitching,
      .pumpGain2x, .capDetectReq, .hvSinkLevel, .lvSinkLevel);
   lsc_host_model HOST (.clock, .scl(sclPin), .sdaDrv, .sdaLine);
   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic ok;
      HOST.xfer(1'b0, a, d, ok);
      chk("write ack", 16'h1, 16'(ok));
   endtask : wr
   task automatic rdChk(input logic [7:0] a, input logic [7:0] exp, input string what);
      logic ok;
      logic [7:0] d;
      HOST.xfer(1'b1, a, d, ok);
      chk("read ack", 16'h1, 16'(ok));
      chk(what, 16'(exp), 16'(d));
   endtask : rdChk
   // Bounded wait; a lapse fails the check.
   task automatic waitGain(input logic v);
      for (int k = 0; k < 40 && pumpGain2x !== v; k++) @(posedge clock);
      chk("pumpGain2x", 16'(v), 16'(pumpGain2x));
   endtask : waitGain
   task automatic print_verdict;
      $display("checks %0d mismatches %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : print_verdict
   initial begin
      repeat (90000) @(posedge clock);
      err_count++;
      print_verdict();
   end
   initial begin
      {nrst, capDetectDone, capPresent, lvDropout, alsCode, patternCode} = '0;
      hardware_enable_pin = 1'b1;
      pwmDuty = 8'hFF;
      repeat (10) @(posedge clock);
      nrst <= 1'b1;
      repeat (4) @(posedge clock);
      rdChk(REG_ANODE, 8'h7F, "anode routing");
      rdChk(REG_BOOST, 8'h00, "boost config");
      rdChk(8'h30, 8'h00, "unmapped read");
      wr(REG_ANODE, 8'h55);
      chk("boostFeedbackSel", 16'h1, boostFeedbackSel);
      chk("pumpFeedbackSel", 16'h15, pumpFeedbackSel);
      chk("shortFaultRef", 16'h55, shortFaultRef);
      wr(REG_BOOST, 8'h02);
      chk("boostFreq1MHz", 16'h1, boostFreq1MHz);
      $display("test routing done");
      for (int i = 0; i < 3; i++) begin
         wr(REG_PUMP, {6'h00, modes[i]});
         chk("pump outputs", 16'(expv[i]), 16'({pumpEnable, pumpSwitching, pumpGain2x}));
      end
      wr(REG_BANK_EN, 8'h04);
      capDetectDone <= 1'b1;
      capPresent <= 1'b1;
      wr(REG_PUMP, {6'h00, PUMP_AUTO});
      chk("pumpGain2x", 16'h0, pumpGain2x);
      lvDropout <= 5'h01;
      waitGain(1'b1);
      lvDropout <= 5'h00;
      repeat (12) @(posedge clock);
      chk("pumpGain2x", 16'h1, pumpGain2x);
      wr(REG_PUMP, {6'h00, PUMP_OFF});
      chk("pumpGain2x", 16'h0, pumpGain2x);
      capDetectDone <= 1'b0;
      capPresent <= 1'b0;
      wr(REG_PUMP, {6'h00, PUMP_AUTO});
      lvDropout <= 5'h01;
      repeat (12) @(posedge clock);
      chk("pumpGain2x", 16'h0, pumpGain2x);
      rdChk(REG_PUMP_STAT, 8'h0C, "pump status");
      lvDropout <= 5'h00;
      $display("test pump done");
      wr(REG_BANK_CFG + 8'h02, 8'h01);
      wr(REG_FULL_SCALE + 8'h02, 8'h1F);
      wr(REG_BRIGHT + 8'h02, 8'hFF);
      chk("lvSinkLevel0", 16'hFFFF, lvSinkLevel[0]);
      wr(REG_PUMP, {6'h00, PUMP_OFF});
      chk("lvSinkLevel0", 16'hFFFF, lvSinkLevel[0]);
      wr(REG_LV_MAP_LO, 8'h01);
      chk("lvSinkLevel0", 16'h0, lvSinkLevel[0]);
      wr(REG_BRIGHT + 8'h02, 8'h80);
      chk("lvSinkLevel1", 16'h8080, lvSinkLevel[1]);
      wr(REG_BANK_EN, 8'h05);
      wr(REG_BANK_CFG, 8'h01);
      wr(REG_FULL_SCALE, 8'h0F);
      wr(REG_BRIGHT, 8'h80);
      chk("hvSinkLevel0", 16'h4040, hvSinkLevel[0]);
      chk("hvSinkLevel1", 16'h4040, hvSinkLevel[1]);
      $display("test levels done");
      hardware_enable_pin <= 1'b0;
      repeat (6) @(posedge clock);
      chk("shutdown", 16'h1, shutdown);
      hardware_enable_pin <= 1'b1;
      repeat (6) @(posedge clock);
      rdChk(REG_ANODE, 8'h7F, "anode after enable");
      chk("lvSinkLevel1", 16'h0, lvSinkLevel[1]);
      $display("test shutdown done");
      print_verdict();
   end
endmodule : led_supply_sink_control_bench

// ==== tb/lsc_host_model.sv ====
// Host model driving the serial register bus.
`timescale 1ns/10ps
module lsc_host_model #(
   parameter logic [6:0] DEV_ADDR = 7'h36
)(
   input logic clock,
   output logic scl,
   output logic sdaDrv,
   input logic sdaLine
);
   // Both lines idle high; the clock stands still between frames.
   initial {scl, sdaDrv} = 2'b11;
   task automatic hold(input int n);
      repeat (n) @(posedge clock);
   endtask : hold
   // One bit, read mid-high; b differs from a only for start and stop.
   task automatic cyc(input logic a, input logic b, output logic s);
      scl <= 1'b0;
      hold(4);
      sdaDrv <= a;
      hold(4);
      scl <= 1'b1;
      hold(4);
      s = sdaLine;
      hold(2);
      sdaDrv <= b;
      hold(6);
   endtask : cyc
   task automatic sendByte(input logic [7:0] v, inout logic ok);
      logic s;
      for (int i = 7; i >= 0; i--) cyc(v[i], v[i], s);
      cyc(1'b1, 1'b1, s);
      ok = ok & !s;
   endtask : sendByte
   // A read NACKs its single byte.
   task automatic xfer(input logic rd, input logic [7:0] a, inout logic [7:0] d, output logic ok);
      logic s;
      ok = 1'b1;
      cyc(1'b1, 1'b0, s);
      sendByte({DEV_ADDR, 1'b0}, ok);
      sendByte(a, ok);
      if (rd) begin
         cyc(1'b1, 1'b0, s);
         sendByte({DEV_ADDR, 1'b1}, ok);
         for (int i = 7; i >= 0; i--) cyc(1'b1, 1'b1, d[i]);
         cyc(1'b1, 1'b1, s);
      end else begin
         sendByte(d, ok);
      end
      cyc(1'b0, 1'b1, s);
   endtask : xfer
endmodule : lsc_host_model

// ==== tb/lsc_sink_control_sva.sv ====
// Port checker for the sink control block.
`timescale 1ns/10ps
module lsc_sink_control_sva
   import lsc_pkg::*;
#(
   parameter int DETECT_CYCLES = 8
)(
   input logic clock,
   input logic nrst,
   input logic shutdown,
   input logic boostFreq1MHz,
   input logic [NUM_HV-1:0] boostFeedbackSel,
   input logic [NUM_LV-1:0] pumpFeedbackSel,
   input logic [NUM_HV+NUM_LV-1:0] shortFaultRef,
   input logic pumpEnable,
   input logic pumpSwitching,
   input logic pumpGain2x,
   input logic capDetectReq,
   input logic [NUM_LV-1:0][15:0] lvSinkLevel
);
   // Sync and state latency add to the detection count.
   localparam int DET_MAX = DETECT_CYCLES + 6;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   // Routing bits drive feedback and fault criteria alike.
   property p_hv_route; boostFeedbackSel == shortFaultRef[1:0]; endproperty
   a_hv_route: assert property (p_hv_route)
      else $error("hv routing vs fault ref");
   property p_lv_route; pumpFeedbackSel == shortFaultRef[6:2]; endproperty
   a_lv_route: assert property (p_lv_route)
      else $error("lv routing vs fault ref");
   property p_reset_vals; $rose(nrst) |-> boostFeedbackSel == 2'h3 && pumpFeedbackSel == 5'h1F && !boostFreq1MHz
      && !pumpEnable; endproperty
   a_reset_vals: assert property (p_reset_vals)
      else $error("reset values wrong");
   // Mapper flops drain a cycle after shutdown.
   property p_off_dark; shutdown [*4] |-> lvSinkLevel == '0; endproperty
   a_off_dark: assert property (p_off_dark)
      else $error("level in shutdown");
   property p_sw_en; pumpSwitching |-> pumpEnable; endproperty
   a_sw_en: assert property (p_sw_en)
      else $error("switching while off");
   property p_gain2x; pumpGain2x |-> pumpEnable && pumpSwitching; endproperty
   a_gain2x: assert property (p_gain2x)
      else $error("2x without pump");
   property p_detect_1x; capDetectReq |-> !pumpGain2x; endproperty
   a_detect_1x: assert property (p_detect_1x)
      else $error("2x in detection");
   property p_detect_end; $rose(capDetectReq) |-> ##[1:DET_MAX] !capDetectReq; endproperty
   a_detect_end: assert property (p_detect_end)
      else $error("detection hung");
endmodule : lsc_sink_control_sva

bind lsc_sink_control lsc_sink_control_sva #(.DETECT_CYCLES(DETECT_CYCLES)) u_sva (.clock, .nrst, .shutdown,
   .boostFreq1MHz, .boostFeedbackSel, .pumpFeedbackSel, .shortFaultRef, .pumpEnable, .pumpSwitching, .pumpGain2x,
   .capDetectReq, .lvSinkLevel);
